// ---- design/sosl_pkg.sv ----
package sosl_pkg;
	typedef enum logic [2:0] {
		SOSL_NORMAL = 3'b000,
		SOSL_VAC    = 3'b001,
		SOSL_SLEEP  = 3'b010,
		SOSL_LIFT   = 3'b011,
		SOSL_ALARM  = 3'b100,
		SOSL_ANNUN  = 3'b101
	} sosl_mode_t;

	// Factory defaults of the retained settings
	localparam logic       VAC_DUAL_RST  = 1'b0;
	localparam logic [3:0] SLEEP_RST     = 4'h1;
	localparam logic [4:0] LIFT_RST      = 5'h11;
	localparam logic [3:0] ALARM_RST     = 4'h0;
	localparam logic [3:0] ANNUN_RST     = 4'h0;

	// Code ranges
	localparam logic [3:0] SLEEP_MAX     = 4'h9;
	localparam logic [4:0] LIFT_MAX      = 5'h13;
	localparam logic [4:0] LIFT_DP_MIN   = 5'h0A;
	localparam logic [3:0] VOL_MAX       = 4'h9;
	localparam logic [3:0] HORN_VOL      = 4'h9;

	// Timing: one base tick of 200 ms at 250 MHz
	localparam int         CLK_MHZ       = 250;
	localparam int         TICK_MS       = 200;
	localparam int         TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;
	localparam int         SLEEP_STEP_MIN = 10;
	localparam int         SLEEP_STEP_TICKS = SLEEP_STEP_MIN * 60 * 1000 / TICK_MS;
	localparam int         LIFT_BASE_MS  = 1000;
	localparam logic [4:0] LIFT_BASE_TICKS = 5'(LIFT_BASE_MS / TICK_MS);
endpackage

// ---- design/sosl_top.sv ----
`timescale 1ns/10ps
module sosl_top #(
	parameter int TICK_CYC = sosl_pkg::TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       key_on,
	input  wire logic       sw_scrub_off,
	input  wire logic       sw_vac,
	input  wire logic       sw_wand,
	input  wire logic       sw_press_dec,
	input  wire logic       sw_horn,
	input  wire logic       throttle_fwd,
	input  wire logic       throttle_rev,
	input  wire logic       recovery_active,
	input  wire logic       machine_active,
	output logic      [3:0] disp_digit,
	output logic            disp_dp,
	output logic            disp_on,
	output logic            ind_vac_yellow,
	output logic            ind_wand_on,
	output logic            ind_batt_red,
	output logic            ind_batt_green,
	output logic            vac_dual,
	output logic            sounder_on,
	output logic      [3:0] sounder_vol,
	output logic            deck_raise,
	output logic            squeegee_raise,
	output logic            accessories_off,
	output logic            squeegee_lift_rev
);
	logic [9:0]             meta_reg;
	logic [9:0]             sync_reg;
	logic [9:0]             prev_reg;
	logic                   s_key;
	logic                   s_scrub;
	logic                   s_vac;
	logic                   s_wand;
	logic                   s_dec;
	logic                   s_horn;
	logic                   s_fwd;
	logic                   s_rev;
	logic                   s_recov;
	logic                   s_active;
	logic                   key_rise;
	logic                   key_fall;
	logic                   vac_press;
	logic                   wand_press;
	logic                   horn_press;
	logic                   rev_rise;

	sosl_pkg::sosl_mode_t   mode_reg;
	sosl_pkg::sosl_mode_t   mode_next;

	logic                   nv_vac_reg;
	logic [3:0]             nv_sleep_reg;
	logic [4:0]             nv_lift_reg;
	logic [3:0]             nv_alarm_reg;
	logic [3:0]             nv_annun_reg;
	logic                   wk_vac_reg;
	logic [3:0]             wk_sleep_reg;
	logic [4:0]             wk_lift_reg;
	logic [3:0]             wk_alarm_reg;
	logic [3:0]             wk_annun_reg;

	logic [31:0]            tick_cnt_reg;
	logic                   tick;
	logic                   flash_reg;
	logic [15:0]            idle_cnt_reg;
	logic [15:0]            sleep_limit;
	logic                   asleep_reg;
	logic [4:0]             lift_cnt_reg;
	logic [3:0]             digit_next;
	logic                   dp_next;
	logic [3:0]             vol_next;

	// Pin inputs pass two flip-flops; edges come from the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else if (ce) begin
			meta_reg <= {key_on, sw_scrub_off, sw_vac, sw_wand, sw_press_dec, sw_horn,
				throttle_fwd, throttle_rev, recovery_active, machine_active};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign {s_key, s_scrub, s_vac, s_wand, s_dec, s_horn, s_fwd, s_rev, s_recov, s_active}
		= sync_reg;
	assign key_rise   = s_key & ~prev_reg[9];
	assign key_fall   = ~s_key & prev_reg[9];
	assign vac_press  = s_vac & ~prev_reg[7];
	assign wand_press = s_wand & ~prev_reg[6];
	assign horn_press = s_horn & ~prev_reg[4];
	assign rev_rise   = s_rev & ~prev_reg[2];

	// Switch combination sampled at key-on picks the setup mode
	always_comb begin
		mode_next = mode_reg;
		if (key_fall) begin
			mode_next = sosl_pkg::SOSL_NORMAL;
		end else if (key_rise) begin
			if (s_scrub && s_vac) begin
				mode_next = sosl_pkg::SOSL_VAC;
			end else if (s_scrub && s_wand) begin
				mode_next = sosl_pkg::SOSL_SLEEP;
			end else if (s_dec && s_vac) begin
				mode_next = sosl_pkg::SOSL_LIFT;
			end else if (s_scrub && s_horn) begin
				mode_next = sosl_pkg::SOSL_ANNUN;
			end else if (s_horn) begin
				mode_next = sosl_pkg::SOSL_ALARM;
			end else begin
				mode_next = sosl_pkg::SOSL_NORMAL;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= sosl_pkg::SOSL_NORMAL;
		end else if (ce) begin
			mode_reg <= mode_next;
		end
	end

	// Working copies step on presses of the selecting switch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wk_vac_reg   <= sosl_pkg::VAC_DUAL_RST;
			wk_sleep_reg <= sosl_pkg::SLEEP_RST;
			wk_lift_reg  <= sosl_pkg::LIFT_RST;
			wk_alarm_reg <= sosl_pkg::ALARM_RST;
			wk_annun_reg <= sosl_pkg::ANNUN_RST;
		end else if (ce) begin
			if (key_rise) begin
				wk_vac_reg   <= nv_vac_reg;
				wk_sleep_reg <= nv_sleep_reg;
				wk_lift_reg  <= nv_lift_reg;
				wk_alarm_reg <= nv_alarm_reg;
				wk_annun_reg <= nv_annun_reg;
			end else begin
				unique case (mode_reg)
					sosl_pkg::SOSL_NORMAL: begin
					end
					sosl_pkg::SOSL_VAC: begin
						if (vac_press) begin
							wk_vac_reg <= ~wk_vac_reg;
						end
					end
					sosl_pkg::SOSL_SLEEP: begin
						if (wand_press) begin
							wk_sleep_reg <= (wk_sleep_reg >= sosl_pkg::SLEEP_MAX) ? 4'h0
								: wk_sleep_reg + 4'h1;
						end
					end
					sosl_pkg::SOSL_LIFT: begin
						if (vac_press) begin
							wk_lift_reg <= (wk_lift_reg >= sosl_pkg::LIFT_MAX) ? 5'h00
								: wk_lift_reg + 5'h01;
						end
					end
					sosl_pkg::SOSL_ALARM: begin
						if (horn_press) begin
							wk_alarm_reg <= (wk_alarm_reg >= sosl_pkg::VOL_MAX) ? 4'h0
								: wk_alarm_reg + 4'h1;
						end
					end
					sosl_pkg::SOSL_ANNUN: begin
						if (horn_press) begin
							wk_annun_reg <= (wk_annun_reg >= sosl_pkg::VOL_MAX) ? 4'h0
								: wk_annun_reg + 4'h1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Retained settings; only the mode being set up is written at key-off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nv_vac_reg   <= sosl_pkg::VAC_DUAL_RST;
			nv_sleep_reg <= sosl_pkg::SLEEP_RST;
			nv_lift_reg  <= sosl_pkg::LIFT_RST;
			nv_alarm_reg <= sosl_pkg::ALARM_RST;
			nv_annun_reg <= sosl_pkg::ANNUN_RST;
		end else if (ce && key_fall) begin
			if (mode_reg == sosl_pkg::SOSL_VAC) begin
				nv_vac_reg <= wk_vac_reg;
			end
			if (mode_reg == sosl_pkg::SOSL_SLEEP) begin
				nv_sleep_reg <= wk_sleep_reg;
			end
			if (mode_reg == sosl_pkg::SOSL_LIFT) begin
				nv_lift_reg <= wk_lift_reg;
			end
			if (mode_reg == sosl_pkg::SOSL_ALARM) begin
				nv_alarm_reg <= wk_alarm_reg;
			end
			if (mode_reg == sosl_pkg::SOSL_ANNUN) begin
				nv_annun_reg <= wk_annun_reg;
			end
		end
	end

	// Base tick and indicator flash
	assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= '0;
			flash_reg    <= 1'b0;
		end else if (ce) begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
			if (tick) begin
				flash_reg <= ~flash_reg;
			end
		end
	end

	// Sleep timer counts idle ticks in normal running
	assign sleep_limit = 16'(nv_sleep_reg * sosl_pkg::SLEEP_STEP_TICKS);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt_reg <= '0;
			asleep_reg   <= 1'b0;
		end else if (ce) begin
			if (!s_key || s_active || mode_reg != sosl_pkg::SOSL_NORMAL
				|| nv_sleep_reg == 4'h0) begin
				idle_cnt_reg <= '0;
				asleep_reg   <= 1'b0;
			end else if (idle_cnt_reg >= sleep_limit) begin
				asleep_reg <= 1'b1;
			end else if (tick) begin
				idle_cnt_reg <= idle_cnt_reg + 16'h1;
			end
		end
	end

	// Reverse squeegee lift: one second plus 0.2 s per code step
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lift_cnt_reg <= '0;
		end else if (ce) begin
			if (!s_rev || !s_recov || !s_key || mode_reg != sosl_pkg::SOSL_NORMAL) begin
				lift_cnt_reg <= '0;
			end else if (rev_rise) begin
				lift_cnt_reg <= sosl_pkg::LIFT_BASE_TICKS + nv_lift_reg;
			end else if (tick && lift_cnt_reg != 5'h00) begin
				lift_cnt_reg <= lift_cnt_reg - 5'h01;
			end
		end
	end

	// Display content and sounder volume
	always_comb begin
		digit_next = 4'h0;
		dp_next    = 1'b0;
		vol_next   = 4'h0;
		unique case (mode_reg)
			sosl_pkg::SOSL_NORMAL: begin
				if (s_key && s_horn) begin
					vol_next = sosl_pkg::HORN_VOL;
				end else if (s_key && s_rev) begin
					vol_next = nv_alarm_reg;
				end else if (s_key && s_fwd) begin
					vol_next = nv_annun_reg;
				end
			end
			sosl_pkg::SOSL_VAC: begin
				digit_next = wk_vac_reg ? 4'h2 : 4'h1;
			end
			sosl_pkg::SOSL_SLEEP: begin
				digit_next = wk_sleep_reg;
			end
			sosl_pkg::SOSL_LIFT: begin
				if (wk_lift_reg >= sosl_pkg::LIFT_DP_MIN) begin
					dp_next    = 1'b1;
					digit_next = 4'(wk_lift_reg - sosl_pkg::LIFT_DP_MIN);
				end else begin
					digit_next = wk_lift_reg[3:0];
				end
			end
			sosl_pkg::SOSL_ALARM: begin
				digit_next = wk_alarm_reg;
				vol_next   = s_rev ? wk_alarm_reg : 4'h0;
			end
			sosl_pkg::SOSL_ANNUN: begin
				digit_next = wk_annun_reg;
				vol_next   = s_fwd ? wk_annun_reg : 4'h0;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disp_digit        <= 4'h0;
			disp_dp           <= 1'b0;
			disp_on           <= 1'b0;
			ind_vac_yellow    <= 1'b0;
			ind_wand_on       <= 1'b0;
			ind_batt_red      <= 1'b0;
			ind_batt_green    <= 1'b0;
			vac_dual          <= 1'b0;
			sounder_on        <= 1'b0;
			sounder_vol       <= 4'h0;
			deck_raise        <= 1'b0;
			squeegee_raise    <= 1'b0;
			accessories_off   <= 1'b0;
			squeegee_lift_rev <= 1'b0;
		end else if (ce) begin
			disp_digit        <= digit_next;
			disp_dp           <= dp_next;
			disp_on           <= mode_reg != sosl_pkg::SOSL_NORMAL;
			ind_vac_yellow    <= (mode_reg == sosl_pkg::SOSL_VAC)
				|| (mode_reg == sosl_pkg::SOSL_LIFT && flash_reg);
			ind_wand_on       <= mode_reg == sosl_pkg::SOSL_SLEEP && flash_reg;
			ind_batt_red      <= mode_reg == sosl_pkg::SOSL_ALARM;
			ind_batt_green    <= mode_reg == sosl_pkg::SOSL_ANNUN;
			vac_dual          <= nv_vac_reg;
			sounder_on        <= vol_next != 4'h0;
			sounder_vol       <= vol_next;
			deck_raise        <= asleep_reg;
			squeegee_raise    <= asleep_reg;
			accessories_off   <= asleep_reg;
			squeegee_lift_rev <= lift_cnt_reg != 5'h00;
		end
	end
endmodule

// ---- dv/sosl_operator.sv ----
`timescale 1ns/10ps
module sosl_operator (
	input  wire logic       clk,
	output logic            key_on,
	output logic      [4:0] sw,
	output logic            fwd,
	output logic            rev,
	output logic            rec,
	output logic            act
);
	initial begin
		key_on = 1'b0;
		sw = 5'h00;
		{fwd, rev, rec, act} = 4'h1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic hold(input logic [4:0] s);
		wait_n(1);
		sw <= s;
	endtask
	// Combination settles before the key turns and is let go once the mode shows
	task automatic power_up(input logic [4:0] s);
		hold(s);
		wait_n(4);
		key_on <= 1'b1;
		wait_n(8);
		sw <= 5'h00;
		wait_n(4);
	endtask
	task automatic press(input logic [4:0] s);
		hold(s);
		wait_n(2);
		sw <= 5'h00;
		wait_n(8);
	endtask
	task automatic key_off();
		wait_n(1);
		key_on <= 1'b0;
		wait_n(8);
	endtask
	task automatic drive(input logic [3:0] v);
		wait_n(1);
		{fwd, rev, rec, act} <= v;
	endtask
endmodule

// ---- dv/sosl_top_asserts.sv ----
`timescale 1ns/10ps
module sosl_top_asserts #(
	parameter int TICK_CYC = 4
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       key_on,
	input  wire logic       sw_horn,
	input  wire logic       throttle_rev,
	input  wire logic       machine_active,
	input  wire logic [3:0] disp_digit,
	input  wire logic       disp_dp,
	input  wire logic       disp_on,
	input  wire logic       ind_batt_red,
	input  wire logic       ind_batt_green,
	input  wire logic       sounder_on,
	input  wire logic [3:0] sounder_vol,
	input  wire logic       deck_raise,
	input  wire logic       squeegee_raise,
	input  wire logic       accessories_off,
	input  wire logic       squeegee_lift_rev
);
	localparam int LIFT_LIM = 24 * TICK_CYC;
	int lift_cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lift_cnt <= 0;
		end else begin
			lift_cnt <= squeegee_lift_rev ? lift_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_digit_range: assert property (disp_on |-> disp_digit <= 4'h9)
		else $error("digit out of range");
	a_dp_lift_only: assert property (
		disp_dp |-> disp_on && !ind_batt_red && !ind_batt_green)
		else $error("decimal point outside lift setup");
	a_setup_quiet: assert property (disp_on |-> !deck_raise && !squeegee_lift_rev)
		else $error("sleep or lift during setup");
	a_sleep_trio: assert property (
		deck_raise == squeegee_raise && squeegee_raise == accessories_off)
		else $error("sleep outputs disagree");
	a_sleep_idle: assert property (machine_active [*5] |-> !deck_raise)
		else $error("sleep while active");
	a_sounder_vol: assert property (sounder_on == (sounder_vol != 4'h0))
		else $error("sounder drive and volume disagree");
	a_horn_full: assert property (
		(key_on && sw_horn && !disp_on) [*8] |-> sounder_vol == 4'h9)
		else $error("horn volume wrong");
	a_lift_rev_only: assert property (!throttle_rev [*5] |-> !squeegee_lift_rev)
		else $error("lift outside reverse");
	a_lift_bounded: assert property (squeegee_lift_rev |-> lift_cnt < LIFT_LIM)
		else $error("lift too long");
	a_red_setup: assert property (ind_batt_red |-> disp_on && !ind_batt_green)
		else $error("red lamp outside alarm setup");
	a_setup_exit: assert property ($fell(key_on) |-> ##[1:6] !disp_on)
		else $error("setup not left at key off");
endmodule
bind sosl_top sosl_top_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.clk, .rstn, .key_on, .sw_horn,
	.throttle_rev, .machine_active, .disp_digit, .disp_dp, .disp_on, .ind_batt_red,
	.ind_batt_green, .sounder_on, .sounder_vol, .deck_raise, .squeegee_raise,
	.accessories_off, .squeegee_lift_rev);

// ---- dv/sosl_tb_top.sv ----
`timescale 1ns/10ps
module sosl_tb_top;
	localparam int          TC = 4;
	localparam logic [19:0] DM = 20'hFC000;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	wire logic   key_on, fwd, rev, rec, act;
	wire logic   [4:0] sw;
	wire logic   [19:0] obs;
	logic        [39:0] q[$];
	int          n_mismatch = 0;
	int          checks_done = 0;
	event        chk_ev;
	always #2 clk = ~clk;
	sosl_top #(.TICK_CYC(TC)) uut (.clk(clk), .rstn(rstn), .ce(ce), .key_on(key_on),
		.sw_scrub_off(sw[4]), .sw_vac(sw[3]), .sw_wand(sw[2]), .sw_press_dec(sw[1]),
		.sw_horn(sw[0]), .throttle_fwd(fwd), .throttle_rev(rev), .recovery_active(rec),
		.machine_active(act), .disp_on(obs[19]), .disp_dp(obs[18]), .disp_digit(obs[17:14]),
		.ind_vac_yellow(obs[13]), .ind_wand_on(obs[12]), .ind_batt_red(obs[11]),
		.ind_batt_green(obs[10]), .vac_dual(obs[9]), .sounder_on(obs[8]),
		.sounder_vol(obs[7:4]), .deck_raise(obs[3]), .squeegee_raise(obs[2]),
		.accessories_off(obs[1]), .squeegee_lift_rev(obs[0]));
	sosl_operator op (.clk(clk), .key_on(key_on), .sw(sw), .fwd(fwd), .rev(rev), .rec(rec),
		.act(act));
	function automatic logic [19:0] dv(input logic dp, input logic [3:0] d);
		return {1'b1, dp, d, 14'h0};
	endfunction
	function automatic logic [19:0] iv(input logic [3:0] x);
		return {6'h0, x, 10'h0};
	endfunction
	function automatic logic [19:0] sv(input logic [3:0] v);
		return {11'h0, v != 4'h0, v, 4'h0};
	endfunction
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error outputs expected %h seen %h", exp, seen);
		end
	endtask
	task automatic ex(input logic [19:0] m, input logic [19:0] v);
		@(negedge clk);
		q.push_back({m, v & m});
		-> chk_ev;
	endtask
	// A flashing lamp is lit for exactly one tick of every two
	task automatic flash(input int b);
		int k;
		k = 0;
		repeat (2 * TC) begin
			@(negedge clk);
			if (obs[b] === 1'b1) begin
				k++;
			end
		end
		check(20'(k), 20'(TC));
	endtask
	always @(chk_ev) begin
		logic [39:0] e;
		e = q.pop_front();
		check(obs & e[39:20], e[19:0]);
	end
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Lift must still stand a tick before its nominal end and be gone just after
	task automatic lift(input int c);
		op.drive(4'h7);
		op.wait_n((5 + c) * TC - 5);
		ex(20'h00001, 20'h00001);
		op.wait_n(12);
		ex(20'h00001, 20'h00000);
		op.drive(4'h3);
	endtask
	initial begin
		int n;
		int m;
		int c;
		void'($urandom(44808));
		fork
			begin
				#200us;
				n_mismatch++;
				wrap_up();
			end
		join_none
		op.wait_n(2);
		rstn <= 1'b1;
		op.power_up(5'h00);
		lift(17);
		op.key_off();
		op.power_up(5'h18);
		ex(20'hFFC00, dv(1'b0, 4'h1) | iv(4'h8));
		for (int i = 0; i < 3; i++) begin
			op.press(5'h08);
			ex(DM, dv(1'b0, (i % 2) ? 4'h1 : 4'h2));
		end
		op.key_off();
		op.power_up(5'h00);
		ex(20'hFFE00, 20'h00200);
		op.key_off();
		op.power_up(5'h0A);
		ex(20'hFCC00, dv(1'b1, 4'h7));
		flash(13);
		for (int i = 0; i < 3; i++) begin
			op.press(5'h08);
			c = (18 + i) % 20;
			ex(DM, dv(c >= 10, 4'(c % 10)));
		end
		op.key_off();
		op.power_up(5'h00);
		lift(0);
		op.key_off();
		op.power_up(5'h14);
		ex(20'hFEC00, dv(1'b0, 4'h1));
		flash(12);
		for (int i = 1; i <= 10; i++) begin
			op.press(5'h04);
			ex(DM, dv(1'b0, 4'((1 + i) % 10)));
		end
		op.key_off();
		op.power_up(5'h00);
		op.drive(4'h0);
		op.wait_n(11975);
		ex(20'h0000E, 20'h00000);
		op.wait_n(50);
		ex(20'h0000E, 20'h0000E);
		op.drive(4'h1);
		op.wait_n(6);
		ex(20'h0000E, 20'h00000);
		op.key_off();
		n = $urandom % 10;
		m = $urandom % 10;
		op.power_up(5'h01);
		ex(20'hFFC00, dv(1'b0, 4'h0) | iv(4'h2));
		repeat (n) op.press(5'h01);
		ex(DM, dv(1'b0, 4'(n)));
		// A press made while the clock enable is low is never seen
		op.wait_n(1);
		ce <= 1'b0;
		op.press(5'h01);
		ex(DM, dv(1'b0, 4'(n)));
		op.wait_n(1);
		ce <= 1'b1;
		op.wait_n(8);
		ex(DM, dv(1'b0, 4'(n)));
		op.drive(4'h5);
		op.wait_n(6);
		ex(20'h001F0, sv(4'(n)));
		op.drive(4'h1);
		op.key_off();
		op.power_up(5'h11);
		ex(20'hFFC00, dv(1'b0, 4'h0) | iv(4'h1));
		repeat (m) op.press(5'h01);
		ex(DM, dv(1'b0, 4'(m)));
		op.drive(4'h9);
		op.wait_n(6);
		ex(20'h001F0, sv(4'(m)));
		op.drive(4'h1);
		op.key_off();
		op.power_up(5'h00);
		op.drive(4'h5);
		op.wait_n(6);
		ex(20'h001F0, sv(4'(n)));
		op.drive(4'h9);
		op.wait_n(6);
		ex(20'h001F0, sv(4'(m)));
		op.drive(4'h1);
		op.hold(5'h01);
		op.wait_n(10);
		ex(20'h001F0, sv(4'h9));
		op.hold(5'h00);
		op.key_off();
		wrap_up();
	end
endmodule
